// ---- sim/serial_peer.sv ----
// Serial peer model: makes the bit clock and records the data line.
module serial_peer (
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic        clr,
  input  wire logic        data_line,
  output logic             pclk,
  output logic      [31:0] hist
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;

  // The bit clock stands low between frames; data is taken on its rising edge.
  always_ff @(posedge mclk) begin
    if (clr) begin
      cnt  <= 2'h0;
      pclk <= 1'b0;
      hist <= 32'h0;
    end else if (run) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) begin
        pclk <= !pclk;
        if (!pclk) begin
          hist <= {hist[30:0], data_line};
        end
      end
    end else begin
      cnt  <= 2'h0;
      pclk <= 1'b0;
    end
  end
endmodule : serial_peer

// ---- sim/sync_serial_tx_test.sv ----
// Self-checking bench for the transmit serial block.
module sync_serial_tx_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sync_serial_pkg::*;
  logic        mclk, rst, wr, rd, rx_start, open_drain, rx_fs, rx_sel, rx_valid;
  logic [31:0] addr, wdata, rdata, rx_in, hist;
  logic        ck_oe, ck_out, fs_out, fs_oe, td_out, td_oe, fs, run, clr, pclk;
  logic [4:0]  rx_len;
  logic [1:0]  dma_size, src;
  int          errors, tests_run;
  logic [4:0]  lens[4]  = '{5'h07, 5'h08, 5'h0f, 5'h10};
  logic [1:0]  sizes[4] = '{DMA_BYTE, DMA_HALF, DMA_HALF, DMA_WORD};
  wire         fs_line  = fs_oe ? fs_out : fs;
  wire         td_line  = td_oe ? td_out : 1'b1;
  wire         ck_line  = ck_oe ? ck_out : (src == SRC_PIN) && pclk;

  sync_serial_tx i_sync_serial_tx (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .div_clock((src == SRC_DIV) && pclk),
    .rx_clock((src == SRC_RX) && pclk), .rx_start(rx_start),
    .tx_clock_pin_in(ck_line), .tx_clock_pin_out(ck_out), .tx_clock_pin_oe(ck_oe),
    .tx_frame_sync_pin_in(fs_line), .tx_frame_sync_pin_out(fs_out),
    .tx_frame_sync_pin_oe(fs_oe), .tx_data_pin_out(td_out), .tx_data_pin_oe(td_oe),
    .tx_data_open_drain(open_drain), .rx_frame_sync_pin_in(rx_fs),
    .rx_edge_select(rx_sel), .rx_word_valid(rx_valid), .rx_word_in(rx_in),
    .rx_word_length(rx_len), .regs_unused_n(), .dma_size(dma_size)
  );

  serial_peer i_serial_peer (
    .mclk(mclk), .run(run), .clr(clr), .data_line(td_line), .pclk(pclk), .hist(hist)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rd_chk

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // One eight-bit word; the record is trimmed of idle zeros at its tail.
  task automatic xfer(input logic [1:0] s, input logic [3:0] st, input logic msb,
                      input logic [31:0] d, input logic [31:0] e);
    logic [31:0] v;
    src <= s;
    clr <= 1'b1;
    fs  <= (st == START_LOW) || (st == START_FALL) || (st == START_EDGE);
    wr_reg(TCMR_ADDR, {20'h0, st, 6'h0, s});
    wr_reg(TFMR_ADDR, {24'h0, msb, 7'h07});
    wr_reg(CTRL_ADDR, 32'h1);
    clr <= 1'b0;
    run <= 1'b1;
    wr_reg(THR_ADDR, d);
    repeat (40) @(posedge mclk);
    if (st != START_CONT) begin
      chk(hist, 32'h0);
      fs       <= !fs;
      rx_start <= (st == START_RX);
      @(posedge mclk);
      rx_start <= 1'b0;
      repeat (24) @(posedge mclk);
      fs <= !fs;
    end
    repeat (140) @(posedge mclk);
    run <= 1'b0;
    v = hist;
    for (int i = 0; i < 32; i++) begin
      if (v != 32'h0 && !v[0]) begin
        v = v >> 1;
      end
    end
    wr_reg(CTRL_ADDR, 32'h0);
    chk(v, e);
  endtask : xfer

  initial begin
    #200000;
    errors++;
    results();
  end

  initial begin
    rst = 1'b1; addr = 32'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0; rx_start = 1'b0;
    open_drain = 1'b0; rx_fs = 1'b0; rx_sel = 1'b0; rx_valid = 1'b0; rx_in = 32'h0;
    rx_len = 5'h0; src = SRC_DIV; fs = 1'b0; run = 1'b0; clr = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(TCMR_ADDR, '1, 32'h0);
    rd_chk(TFMR_ADDR, '1, 32'h0);
    rd_chk(32'hfffbc02c, '1, 32'h0);
    wr_reg(TCMR_ADDR, 32'ha5c30746);
    rd_chk(TCMR_ADDR, '1, 32'ha5c30746);
    wr_reg(TFMR_ADDR, 32'hfe9fffff);
    rd_chk(TFMR_ADDR, '1, 32'h009f0fbf);
    for (int i = 0; i < 4; i++) begin
      wr_reg(TFMR_ADDR, {27'h0, lens[i]});
      repeat (2) @(posedge mclk);
      chk(32'(dma_size), 32'(sizes[i]));
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(TFMR_ADDR, {9'h0, 3'(i), 20'h7});
      repeat (2) @(posedge mclk);
      chk(32'(fs_oe), 32'(i != 0));
      chk(32'(fs_out), 32'(i == 1 || i == 3));
    end
    for (int m = 0; m < 3; m++) begin
      wr_reg(TCMR_ADDR, {27'h0, 3'(m), SRC_DIV});
      repeat (2) @(posedge mclk);
      chk(32'(ck_oe), 32'(m != 0));
    end
    clr <= 1'b1;
    wr_reg(TCMR_ADDR, {26'h0, 1'b1, CLK_OUT_CONT, SRC_DIV});
    wr_reg(CTRL_ADDR, 32'h1);
    clr <= 1'b0;
    run <= 1'b1;
    repeat (7) @(posedge mclk);
    #1 chk(32'(ck_out), 32'h1);
    repeat (4) @(posedge mclk);
    #1 chk(32'(ck_out), 32'h0);
    run <= 1'b0;
    wr_reg(CTRL_ADDR, 32'h0);
    xfer(SRC_PIN, START_CONT, 1'b0, 32'h18d, 32'hb1);
    xfer(SRC_PIN, START_CONT, 1'b1, 32'h18d, 32'h8d);
    xfer(SRC_DIV, START_CONT, 1'b0, 32'h8d, 32'hb1);
    xfer(SRC_RX, START_CONT, 1'b0, 32'h8d, 32'hb1);
    // Only defined start codes are programmed.
    for (int c = 1; c < 8; c++) begin
      xfer(SRC_PIN, 4'(c), 1'b0, 32'h8d, 32'hb1);
    end
    wr_reg(TFMR_ADDR, 32'h27);
    repeat (2) @(posedge mclk);
    chk({30'h0, td_oe, td_out}, 32'h3);
    open_drain <= 1'b1;
    wr_reg(TFMR_ADDR, 32'h07);
    repeat (2) @(posedge mclk);
    chk({30'h0, td_oe, td_out}, 32'h0);
    open_drain <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      rx_len   <= (i == 0) ? 5'h07 : 5'h0f;
      rx_in    <= 32'hf2345678;
      rx_valid <= 1'b1;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rd_chk(RHR_ADDR, '1, (i == 0) ? 32'h78 : 32'h5678);
    end
    wr_reg(RHR_ADDR, 32'h0);
    rd_chk(RHR_ADDR, '1, 32'h5678);
    src <= SRC_PIN;
    run <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr_reg(TFMR_ADDR, {7'h0, 1'(s), 24'h7});
      rx_sel <= 1'(s);
      fs     <= !1'(s);
      rx_fs  <= !1'(s);
      repeat (20) @(posedge mclk);
      rd_chk(SR_ADDR, 32'h0, 32'h0);
      fs    <= 1'(s);
      rx_fs <= 1'(s);
      repeat (20) @(posedge mclk);
      rd_chk(SR_ADDR, 32'hc00, 32'h0);
      fs    <= !1'(s);
      rx_fs <= !1'(s);
      repeat (20) @(posedge mclk);
      rd_chk(SR_ADDR, 32'hc00, 32'hc00);
      rd_chk(SR_ADDR, 32'hc00, 32'h0);
    end
    run <= 1'b0;
    results();
  end
endmodule : sync_serial_tx_test

// ---- src/sync_serial_pkg.sv ----
// Package with register map, field layouts, codes and state for the transmit serial block.
package sync_serial_pkg;
  localparam logic [31:0] CTRL_ADDR = 32'hfffbc000;
  localparam logic [31:0] TCMR_ADDR = 32'hfffbc018;
  localparam logic [31:0] TFMR_ADDR = 32'hfffbc01c;
  localparam logic [31:0] RHR_ADDR  = 32'hfffbc020;
  localparam logic [31:0] THR_ADDR  = 32'hfffbc024;
  localparam logic [31:0] TSHR_ADDR = 32'hfffbc034;
  localparam logic [31:0] SR_ADDR   = 32'hfffbc040;

  localparam logic [1:0] SRC_DIV = 2'h0;
  localparam logic [1:0] SRC_RX  = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam logic [2:0] CLK_OUT_NONE = 3'h0;
  localparam logic [2:0] CLK_OUT_CONT = 3'h1;
  localparam logic [2:0] CLK_OUT_XFER = 3'h2;
  localparam logic [1:0] GATE_LOW  = 2'h1;
  localparam logic [1:0] GATE_HIGH = 2'h2;
  localparam logic [3:0] START_CONT = 4'h0;
  localparam logic [3:0] START_RX   = 4'h1;
  localparam logic [3:0] START_LOW  = 4'h2;
  localparam logic [3:0] START_HIGH = 4'h3;
  localparam logic [3:0] START_FALL = 4'h4;
  localparam logic [3:0] START_RISE = 4'h5;
  localparam logic [3:0] START_CHG  = 4'h6;
  localparam logic [3:0] START_EDGE = 4'h7;
  localparam logic [2:0] SYNC_OUT_NONE = 3'h0;
  localparam logic [2:0] SYNC_OUT_NEG  = 3'h1;
  localparam logic [2:0] SYNC_OUT_POS  = 3'h2;
  localparam logic [2:0] SYNC_OUT_LOW  = 3'h3;
  localparam logic [2:0] SYNC_OUT_HIGH = 3'h4;
  localparam logic [2:0] SYNC_OUT_TOG  = 3'h5;
  localparam logic [4:0] LEN_BYTE_MAX = 5'h07;
  localparam logic [4:0] LEN_HALF_MAX = 5'h0f;
  localparam logic [1:0] DMA_BYTE = 2'h0;
  localparam logic [1:0] DMA_HALF = 2'h1;
  localparam logic [1:0] DMA_WORD = 2'h2;
  localparam int SR_TXRDY = 0;
  localparam int SR_TXEMPTY = 1;
  localparam int SR_TX_SYNC = 10;
  localparam int SR_RX_SYNC = 11;
  localparam int SR_TXEN = 16;
  localparam int CTRL_TXEN = 0;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] start_delay;
    logic [3:0] rsv;
    logic [3:0] start;
    logic [1:0] clock_gating_select;
    logic       clock_invert;
    logic [2:0] clock_output_mode;
    logic [1:0] clock_source_select;
  } tx_clock_mode_t;

  typedef struct packed {
    logic [6:0] rsv3;
    logic       frame_sync_edge_select;
    logic       frame_sync_data_enable;
    logic [2:0] frame_sync_output_select;
    logic [3:0] frame_sync_length;
    logic [3:0] rsv2;
    logic [3:0] words_per_frame;
    logic       bit_order;
    logic       rsv1;
    logic       idle_data_level;
    logic [4:0] word_length;
  } tx_frame_mode_t;

  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_wait = 4'h2,
    st_delay = 4'h4,
    st_data = 4'h8
  } tx_state_t;

  typedef struct packed {
    tx_state_t      st;
    tx_clock_mode_t tcmr;
    tx_frame_mode_t tfmr;
    logic           tx_enable;
    logic [31:0]    thr;
    logic           thr_full;
    logic [15:0]    tshr;
    logic [31:0]    shreg;
    logic [31:0]    rx_word;
    logic [31:0]    rdata;
    logic [4:0]     bit_idx;
    logic [4:0]     bit_cnt;
    logic [3:0]     word_cnt;
    logic [7:0]     dly;
    logic [3:0]     sync_cnt;
    logic [3:0]     fs_cnt;
    logic [8:0]     per_cnt;
    logic           fs_tog;
    logic           clk_q;
    logic           tf_q;
    logic           tf_samp;
    logic           rf_q;
    logic           ck_out;
    logic           fs_out;
    logic           td_out;
    logic           tx_sync_flag;
    logic           rx_sync_flag;
    logic [1:0]     dma_size;
  } tx_regs_t;
endpackage : sync_serial_pkg

// ---- src/sync_serial_tx.sv ----
// Transmit clock/frame engine of a synchronous serial controller with its register port.
// Function
// - bit clock from divided clock, receive clock or clock pin by select code.
// - clock pin input only, continuous output, or output only during transfers.
// - inversion swaps the shifting edge and frame sync sampling edge.
// - inversion never affects the clock driven on the pin.
// - clock gating off, or clock runs only while frame sync low or high.
// - start code zero sends when holding register written, words back to back.
// - other start codes use receiver start or frame sync levels and edges.
// - nonzero start delay waits that many transmit clocks, also for receiver start.
// - a short delay lets data words replace the remaining sync data bits.
// - nonzero period makes a frame sync every 2*(period+1) transmit clocks.
// - each word carries word length plus one bits; zero is forbidden.
// - DMA moves bytes, half-words or words according to word length.
// - data line idles at the idle level; open-drain drives only a one.
// - bit order selects least or most significant bit first.
// - each start sends words per frame plus one words; under start code zero it stops early once the holding register is empty.
// - frame sync length sets sync duration and sync data bit count.
// - frame sync pin input only, pulses, transfer levels or toggle by code.
// - sync data enable sends the sync holding register during the start delay.
// - transmit sync event on rising or falling frame sync edge by select.
// - receive sync event on rising or falling receive frame sync edge.
// - received words stand right aligned in the receive holding register.
// - transmit sync flag stays set until software reads the status.
module sync_serial_tx (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        div_clock,
  input  wire logic        rx_clock,
  input  wire logic        rx_start,
  input  wire logic        tx_clock_pin_in,
  output logic             tx_clock_pin_out,
  output logic             tx_clock_pin_oe,
  input  wire logic        tx_frame_sync_pin_in,
  output logic             tx_frame_sync_pin_out,
  output logic             tx_frame_sync_pin_oe,
  output logic             tx_data_pin_out,
  output logic             tx_data_pin_oe,
  input  wire logic        tx_data_open_drain,
  input  wire logic        rx_frame_sync_pin_in,
  input  wire logic        rx_edge_select,
  input  wire logic        rx_word_valid,
  input  wire logic [31:0] rx_word_in,
  input  wire logic [4:0]  rx_word_length,
  output sync_serial_pkg::tx_regs_t regs_unused_n,
  output logic      [1:0]  dma_size
);
  import sync_serial_pkg::*;

  tx_regs_t s;
  tx_regs_t next_s;
  logic     clk_lvl;
  logic     tf_lvl;
  logic     gate_ok;
  logic     rise;
  logic     fall;
  logic     shift_ev;
  logic     samp_ev;
  logic     start_ev;
  logic     load;
  logic     sr_read;
  logic     tx_edge;
  logic     rx_edge;
  logic [31:0] status;

  function automatic logic [4:0] first_bit(input logic msb_first, input logic [4:0] len);
    first_bit = msb_first ? len : 5'h00;
  endfunction : first_bit

  function automatic logic [31:0] right_align(input logic [31:0] w, input logic [4:0] len);
    logic [31:0] m;
    m = 32'hffffffff >> (5'h1f - len);
    right_align = w & m;
  endfunction : right_align

  function automatic logic [1:0] dma_unit(input logic [4:0] len);
    if (len <= LEN_BYTE_MAX) begin
      dma_unit = DMA_BYTE;
    end else if (len <= LEN_HALF_MAX) begin
      dma_unit = DMA_HALF;
    end else begin
      dma_unit = DMA_WORD;
    end
  endfunction : dma_unit

  always_comb begin
    next_s = s;
    load = 1'b0;
    start_ev = 1'b0;
    case (s.tcmr.clock_source_select)
      SRC_DIV: clk_lvl = div_clock;
      SRC_RX:  clk_lvl = rx_clock;
      SRC_PIN: clk_lvl = tx_clock_pin_in;
      default: clk_lvl = 1'b0;
    endcase
    tf_lvl = (s.tfmr.frame_sync_output_select != SYNC_OUT_NONE) ? s.fs_out : tx_frame_sync_pin_in;
    case (s.tcmr.clock_gating_select)
      GATE_LOW:  gate_ok = ~tf_lvl;
      GATE_HIGH: gate_ok = tf_lvl;
      default:  gate_ok = 1'b1;
    endcase
    rise = clk_lvl & ~s.clk_q & gate_ok;
    fall = ~clk_lvl & s.clk_q & gate_ok;
    shift_ev = s.tcmr.clock_invert ? rise : fall;
    samp_ev = s.tcmr.clock_invert ? fall : rise;
    next_s.clk_q = clk_lvl;
    next_s.tf_q = tf_lvl;
    if (samp_ev) begin
      next_s.tf_samp = tf_lvl;
    end
    // The pin sees the selected clock before inversion.
    case (s.tcmr.clock_output_mode)
      CLK_OUT_CONT: next_s.ck_out = clk_lvl;
      CLK_OUT_XFER: next_s.ck_out = clk_lvl & (s.st == st_data);
      default:  next_s.ck_out = 1'b0;
    endcase
    case (s.tcmr.start)
      START_CONT: start_ev = s.thr_full;
      START_RX:   start_ev = rx_start;
      START_LOW:  start_ev = samp_ev & ~tf_lvl;
      START_HIGH: start_ev = samp_ev & tf_lvl;
      START_FALL: start_ev = samp_ev & s.tf_samp & ~tf_lvl;
      START_RISE: start_ev = samp_ev & ~s.tf_samp & tf_lvl;
      START_CHG:  start_ev = samp_ev & (s.tf_samp != tf_lvl);
      START_EDGE: start_ev = s.tf_q != tf_lvl;
      default:    start_ev = 1'b0;
    endcase
    if (shift_ev && s.fs_cnt != 4'h0) begin
      next_s.fs_cnt = s.fs_cnt - 4'h1;
    end
    if (shift_ev && s.tcmr.period != 8'h00) begin
      if (s.per_cnt >= {s.tcmr.period, 1'b1}) begin
        next_s.per_cnt = 9'h000;
        next_s.fs_cnt = s.tfmr.frame_sync_length;
        next_s.fs_tog = ~s.fs_tog;
      end else begin
        next_s.per_cnt = s.per_cnt + 9'h001;
      end
    end
    case (s.st)
      st_idle: begin
        next_s.td_out = s.tfmr.idle_data_level;
        if (s.tx_enable) begin
          next_s.st = st_wait;
        end
      end
      st_wait: begin
        if (shift_ev) begin
          next_s.td_out = s.tfmr.idle_data_level;
        end
        if (start_ev) begin
          next_s.word_cnt = 4'h0;
          next_s.dly = 8'h00;
          next_s.sync_cnt = 4'h0;
          next_s.fs_cnt = s.tfmr.frame_sync_length;
          next_s.fs_tog = ~s.fs_tog;
          if (s.tcmr.start_delay != 8'h00) begin
            next_s.st = st_delay;
          end else begin
            next_s.st = st_data;
            load = 1'b1;
          end
        end
      end
      st_delay: begin
        if (shift_ev) begin
          if (s.tfmr.frame_sync_data_enable
              && s.sync_cnt < s.tfmr.frame_sync_length) begin
            next_s.td_out = s.tshr[s.sync_cnt];
            next_s.sync_cnt = s.sync_cnt + 4'h1;
          end else begin
            next_s.td_out = s.tfmr.idle_data_level;
          end
          next_s.dly = s.dly + 8'h01;
          if (s.dly + 8'h01 >= s.tcmr.start_delay) begin
            next_s.st = st_data;
            load = 1'b1;
          end
        end
      end
      st_data: begin
        if (shift_ev) begin
          next_s.td_out = s.shreg[s.bit_idx];
          next_s.bit_cnt = s.bit_cnt + 5'h01;
          next_s.bit_idx = s.tfmr.bit_order ? s.bit_idx - 5'h01 : s.bit_idx + 5'h01;
          if (s.bit_cnt >= s.tfmr.word_length) begin
            if (s.word_cnt >= s.tfmr.words_per_frame) begin
              next_s.st = st_wait;
            end else if (s.tcmr.start == START_CONT && !s.thr_full) begin
              next_s.st = st_wait;
            end else begin
              next_s.word_cnt = s.word_cnt + 4'h1;
              load = 1'b1;
            end
          end
        end
      end
      default: next_s.st = st_idle;
    endcase
    if (load) begin
      next_s.shreg = s.thr;
      next_s.thr_full = 1'b0;
      next_s.bit_cnt = 5'h00;
      next_s.bit_idx = first_bit(s.tfmr.bit_order, s.tfmr.word_length);
    end
    if (!s.tx_enable) begin
      next_s.st = st_idle;
    end
    case (s.tfmr.frame_sync_output_select)
      SYNC_OUT_NEG:  next_s.fs_out = s.fs_cnt == 4'h0;
      SYNC_OUT_POS:  next_s.fs_out = s.fs_cnt != 4'h0;
      SYNC_OUT_LOW:  next_s.fs_out = s.st != st_data;
      SYNC_OUT_HIGH: next_s.fs_out = s.st == st_data;
      SYNC_OUT_TOG:  next_s.fs_out = s.fs_tog;
      default:   next_s.fs_out = 1'b0;
    endcase
    tx_edge = s.tfmr.frame_sync_edge_select ? (s.tf_q & ~tf_lvl) : (~s.tf_q & tf_lvl);
    rx_edge = rx_edge_select ? (s.rf_q & ~rx_frame_sync_pin_in)
                             : (~s.rf_q & rx_frame_sync_pin_in);
    next_s.rf_q = rx_frame_sync_pin_in;
    sr_read = rd && addr == SR_ADDR;
    // A new event in the clearing cycle keeps the flag set.
    next_s.tx_sync_flag = (s.tx_sync_flag & ~sr_read) | tx_edge;
    next_s.rx_sync_flag = (s.rx_sync_flag & ~sr_read) | rx_edge;
    if (rx_word_valid) begin
      next_s.rx_word = right_align(rx_word_in, rx_word_length);
    end
    next_s.dma_size = dma_unit(s.tfmr.word_length);
    status = 32'h00000000;
    status[SR_TXRDY] = ~s.thr_full;
    status[SR_TXEMPTY] = ~s.thr_full & (s.st != st_data) & (s.st != st_delay);
    status[SR_TX_SYNC] = s.tx_sync_flag;
    status[SR_RX_SYNC] = s.rx_sync_flag;
    status[SR_TXEN] = s.tx_enable;
    next_s.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        CTRL_ADDR: next_s.rdata[CTRL_TXEN] = s.tx_enable;
        TCMR_ADDR: next_s.rdata = s.tcmr;
        TFMR_ADDR: next_s.rdata = s.tfmr;
        RHR_ADDR:  next_s.rdata = s.rx_word;
        TSHR_ADDR: next_s.rdata = {16'h0000, s.tshr};
        SR_ADDR:   next_s.rdata = status;
        default:   next_s.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (addr)
        CTRL_ADDR: next_s.tx_enable = wdata[CTRL_TXEN];
        TCMR_ADDR: begin
          next_s.tcmr = wdata;
          next_s.tcmr.rsv = 4'h0;
        end
        TFMR_ADDR: begin
          next_s.tfmr = wdata;
          next_s.tfmr.rsv1 = 1'b0;
          next_s.tfmr.rsv2 = 4'h0;
          next_s.tfmr.rsv3 = 7'h00;
        end
        THR_ADDR: begin
          next_s.thr = wdata;
          next_s.thr_full = 1'b1;
        end
        TSHR_ADDR: next_s.tshr = wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.st <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign regs_unused_n = s;
  assign dma_size = s.dma_size;
  assign tx_clock_pin_out = s.ck_out;
  assign tx_clock_pin_oe = s.tcmr.clock_output_mode == CLK_OUT_CONT
                         || s.tcmr.clock_output_mode == CLK_OUT_XFER;
  assign tx_frame_sync_pin_out = s.fs_out;
  assign tx_frame_sync_pin_oe = s.tfmr.frame_sync_output_select != SYNC_OUT_NONE
                              && s.tfmr.frame_sync_output_select <= SYNC_OUT_TOG;
  assign tx_data_pin_out = s.td_out;
  assign tx_data_pin_oe = ~tx_data_open_drain | s.td_out;

  sequence status_read_s;
    rd && addr == SR_ADDR;
  endsequence

  sequence idle_run_s;
    s.st == st_idle ##1 s.st == st_idle;
  endsequence

  clk_pin_off_a: assert property (@(posedge mclk) disable iff (rst)
    s.tcmr.clock_output_mode == CLK_OUT_NONE |-> !tx_clock_pin_oe)
    else $error("clock pin driven while input only");
  clk_pin_gap_a: assert property (@(posedge mclk) disable iff (rst)
    s.tcmr.clock_output_mode == CLK_OUT_XFER && s.st != st_data |=> !tx_clock_pin_out)
    else $error("clock pin toggles outside transfer");
  idle_level_a: assert property (@(posedge mclk) disable iff (rst)
    idle_run_s |-> tx_data_pin_out == $past(s.tfmr.idle_data_level))
    else $error("data pin not at idle level");
  open_drain_a: assert property (@(posedge mclk) disable iff (rst)
    tx_data_open_drain && !tx_data_pin_out |-> !tx_data_pin_oe)
    else $error("open drain pin drives zero");
  bit_count_a: assert property (@(posedge mclk) disable iff (rst)
    s.st == st_data && s.tfmr.word_length != 5'h00 |-> s.bit_cnt <= s.tfmr.word_length)
    else $error("word exceeds its length");
  word_count_a: assert property (@(posedge mclk) disable iff (rst)
    s.st == st_data |-> s.word_cnt <= s.tfmr.words_per_frame)
    else $error("too many words in frame");
  start_delay_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(s.st == st_delay) |-> s.dly == 8'h00 && s.tcmr.start_delay != 8'h00)
    else $error("delay entered wrongly");
  sync_clear_a: assert property (@(posedge mclk) disable iff (rst)
    status_read_s ##1 !$rose(s.tf_q) && !$fell(s.tf_q) |-> !s.tx_sync_flag)
    else $error("sync flag not cleared by read");
  sync_hold_a: assert property (@(posedge mclk) disable iff (rst)
    s.tx_sync_flag && !(rd && addr == SR_ADDR) |=> s.tx_sync_flag)
    else $error("sync flag lost");
  rx_read_a: assert property (@(posedge mclk) disable iff (rst)
    rd && addr == RHR_ADDR |=> rdata == $past(s.rx_word))
    else $error("receive word read wrong");
  fs_high_a: assert property (@(posedge mclk) disable iff (rst)
    s.tfmr.frame_sync_output_select == SYNC_OUT_HIGH && s.st == st_data
    ##1 s.tfmr.frame_sync_output_select == SYNC_OUT_HIGH |-> tx_frame_sync_pin_out)
    else $error("frame sync not high in transfer");
endmodule : sync_serial_tx
